//--- cir_card_regs.sv
// card identity register bank behind an apb slave
//
// Notes on behaviour
// - busy bit low until power-up finishes
// - access mode bits 30:29, byte or sector
// - 1.7-1.95V bit set, 2.7-3.6V bits set
// - reserved conditions bits read zero
// - maker, package type 1, oem zero
// - name, revision, serial, date fields
// - identification crc7 at 7:1, bit0 one
// - structure 3, spec version 4
// - access times 4Fh, 1h; clock 32h
// - command classes field F5h
// - 512-byte blocks, no partial or misaligned
// - size FFFh, size multiplier 7h
// - four current fields all 7h
// - erase 1Fh/1Fh, protect group 0Fh, enabled
// - write speed factor 2h
// - driver stage register absent
// - protection and copy bits zero
// - ecc and format fields zero
// - card data crc 30h, bit0 one
`timescale 1ns/1ps
`default_nettype none
module cir_card_regs import cir_pkg::*; #(
    parameter int unsigned POWERUP_CYCLES_P = POWERUP_CYCLES,
    // arbitrary neutral identity values
    parameter logic [7:0] MAKER_CODE = 8'h5a,
    parameter logic [47:0] PRODUCT_NAME = 48'h585858585858,
    parameter logic [7:0] PRODUCT_REVISION = 8'h10,
    // per-unit production values
    parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,
    parameter logic [7:0] MANUFACTURE_DATE = 8'h00
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb request
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // apb answer
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam logic [6:0] CRC_LAST = 7'(CRC_SPAN - 1);
    localparam logic [2:0] FILL_LAST = 3'(STORE_WORDS - 1);
    localparam logic [WAIT_W-1:0] WAIT_LAST = WAIT_W'(POWERUP_CYCLES_P - 1);

    // identification body above the checksum
    // maker package oem
    localparam logic [119:0] CID_BODY = {
        MAKER_CODE, CID_RSVD, CID_PKG_TYPE, CID_OEM,
        PRODUCT_NAME, PRODUCT_REVISION, SERIAL_NUMBER, MANUFACTURE_DATE
    };

    localparam logic [127:0] CSD_WORD = {
        CSD_STRUCT, CSD_SPEC, 2'h0,
        CSD_ASYNC_ACCESS_TIME, CSD_CLOCKED_ACCESS_TIME, CSD_MAXCLK,
        CSD_CLASSES,
        CSD_BLKLEN, 1'b0, 1'b0, 1'b0,
        1'b0, 2'h0,
        CSD_SIZE,
        CSD_CURRENT, CSD_CURRENT, CSD_CURRENT, CSD_CURRENT,
        CSD_SIZE_MULT,
        CSD_ERASE_SIZE, CSD_ERASE_MULT, CSD_PROT_SIZE, 1'b1,
        2'h0,
        CSD_W_SPEED,
        CSD_BLKLEN, 1'b0, 4'h0,
        1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
        2'h0, 2'h0,
        CSD_CRC, 1'b1
    };

    cir_phase_t phase;
    logic [6:0] crc_cnt;
    logic [6:0] crc_acc;
    logic [2:0] fill_idx;
    logic [WAIT_W-1:0] wait_cnt;
    logic powered;
    logic sector_mode;
    logic [127:0] cid_word;
    logic [31:0] opcond_word;
    logic [31:0] fill_data;
    logic [31:0] store_rdata;
    logic setup_phase;
    logic access_edge;
    logic done_edge;
    logic store_wr;
    logic [3:0] slot;

    // map an address onto the word store: {hit, index}
    function automatic logic [3:0] store_slot(input logic [7:0] a);
        logic [3:0] s;
        s = 4'h0;
        if (a[1:0] == 2'h0 && a >= OFS_CID0 && a < OFS_CTRL) begin
            // a[5] picks identification (slots 0-3) or card data (4-7), as filled
            s = {1'b1, a[5], a[3:2]};
        end
        return s;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        logic [3:0] s;
        s = store_slot(a);
        return s[3] || a == OFS_OPCOND || a == OFS_CTRL || a == OFS_STAT;
    endfunction

    // next crc7 state for one message bit
    function automatic logic [6:0] crc_step(input logic [6:0] c, input logic d);
        logic fb;
        fb = d ^ c[6];
        return {c[5:0], 1'b0} ^ (fb ? CRC_POLY : 7'h00);
    endfunction

    assign setup_phase = psel && !penable;
    assign access_edge = psel && penable && !pready;
    assign done_edge = psel && penable && pready;

    // decoded once; a select straight on a call result is not portable
    assign slot = store_slot(paddr);

    assign cid_word = {CID_BODY, crc_acc, 1'b1};

    assign opcond_word = {powered, (sector_mode ? MODE_SECTOR : MODE_BYTE),
                          OPC_RSVD_HI, OPC_HIGH_V, OPC_MID_V, OPC_LOW_V, OPC_RSVD_LO};

    assign fill_data = fill_idx[2] ? CSD_WORD[{fill_idx[1:0], 5'h00} +: 32]
                                   : cid_word[{fill_idx[1:0], 5'h00} +: 32];
    // store loaded once from constants; nothing else ever writes it
    assign store_wr = (phase == cir_fill);

    // power-up sequence: checksum, load store, settle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= cir_crc;
        end else begin
            unique case (phase)
                cir_crc: begin
                    if (crc_cnt == CRC_LAST) begin
                        phase <= cir_fill;
                    end
                end
                cir_fill: begin
                    if (fill_idx == FILL_LAST) begin
                        phase <= cir_wait;
                    end
                end
                cir_wait: begin
                    if (wait_cnt == WAIT_LAST) begin
                        phase <= cir_ready;
                    end
                end
                cir_ready: begin
                    phase <= cir_ready;
                end
            endcase
        end
    end

    // serial rather than parallel: 120 cycles once, far less logic
    // serial crc7 over bits 127:8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_cnt <= 7'h00;
            crc_acc <= 7'h00;
        end else if (phase == cir_crc) begin
            crc_acc <= crc_step(crc_acc, CID_BODY[CRC_LAST - crc_cnt]);
            crc_cnt <= crc_cnt + 7'h01;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fill_idx <= 3'h0;
        end else if (phase == cir_fill) begin
            fill_idx <= fill_idx + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt <= '0;
        end else if (phase == cir_wait) begin
            wait_cnt <= wait_cnt + WAIT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powered <= 1'b0;
        end else if (phase == cir_wait && wait_cnt == WAIT_LAST) begin
            powered <= 1'b1;
        end
    end

    // pstrb[0] gates the only writable bit in the map
    // software picks byte or sector mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sector_mode <= CTRL_RESET[CTRL_SECTOR_BIT];
        end else if (done_edge && pwrite && paddr == OFS_CTRL && pstrb[0]) begin
            sector_mode <= pwdata[CTRL_SECTOR_BIT];
        end
    end

    // identity words; the host has no write path here
    cir_word_store #(
        .WIDTH(32),
        .DEPTH(STORE_WORDS),
        .AW(STORE_AW)
    ) cir_word_store_i (
        .clk(pclk),
        .wr_en(store_wr),
        .wr_addr(fill_idx),
        .wr_data(fill_data),
        .rd_en(setup_phase),
        .rd_addr(slot[2:0]),
        .rd_data(store_rdata)
    );

    // one wait state so the store read lands first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access_edge;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= access_edge && !is_mapped(paddr);
        end
    end

    // reads only; writes to words are ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (access_edge) begin
            if (pwrite || !is_mapped(paddr)) begin
                prdata <= 32'h0000_0000;
            end else if (slot[3]) begin
                prdata <= store_rdata;
            end else if (paddr == OFS_OPCOND) begin
                prdata <= opcond_word;
            end else if (paddr == OFS_CTRL) begin
                prdata <= {31'h0, sector_mode};
            end else begin
                prdata <= {29'h0, phase, powered};
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence opcond_read;
        access_edge && !pwrite && paddr == OFS_OPCOND;
    endsequence

    busy_bit_a: assert property (opcond_read |=> prdata[OPC_BUSY_BIT] == $past(powered))
        else $error("busy bit does not follow power-up state");

    powerup_time_a: assert property ($rose(powered) |-> $past(wait_cnt) == WAIT_LAST)
        else $error("busy released before the power-up count");

    mode_report_a: assert property (opcond_read |=>
        prdata[OPC_MODE_LO +: 2] == ($past(sector_mode) ? MODE_SECTOR : MODE_BYTE))
        else $error("access mode field wrong");

    opcond_fixed_a: assert property (opcond_read |=> prdata[28:0] == 29'h00ff_8080)
        else $error("voltage or reserved bits wrong");

    crc_span_a: assert property ($rose(phase == cir_fill) |-> $past(crc_cnt) == CRC_LAST)
        else $error("checksum did not cover 120 bits");

    cid_tail_a: assert property (store_wr && fill_idx == 3'h0 |->
        fill_data[7:0] == {crc_acc, 1'b1} && crc_cnt == 7'(CRC_SPAN))
        else $error("identification tail wrong");

    csd_tail_a: assert property (store_wr && fill_idx == 3'h4 |-> fill_data[7:0] == 8'h61)
        else $error("card data checksum byte wrong");

    csd_head_a: assert property (store_wr && fill_idx == 3'h7 |-> fill_data == 32'hd04f_0132)
        else $error("card data top word wrong");

    ro_write_a: assert property (done_edge && pwrite && paddr != OFS_CTRL |=> $stable(sector_mode))
        else $error("write outside control changed state");

    answer_once_a: assert property (access_edge ##1 pready |=> !pready ##0 $stable(prdata))
        else $error("answer stood longer than one cycle");

    unmapped_err_a: assert property (access_edge && !is_mapped(paddr) |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");

    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");

    status_ready_a: assert property (access_edge && !pwrite && paddr == OFS_STAT && phase == cir_ready |=>
        prdata == 32'h0000_0007)
        else $error("status not ready after power-up");

    cid_read_a: assert property (access_edge && !pwrite && paddr == OFS_CID0 && phase == cir_ready |=>
        prdata == cid_word[31:0])
        else $error("identification low word read wrong");

    ctrl_read_a: assert property (access_edge && !pwrite && paddr == OFS_CTRL |=>
        prdata == {31'h0, $past(sector_mode)})
        else $error("control read-back wrong");

    busy_read_c: cover property (opcond_read ##1 !prdata[OPC_BUSY_BIT]);
    ready_read_c: cover property (opcond_read ##1 prdata[OPC_BUSY_BIT]);
    sector_mode_c: cover property ($rose(sector_mode));
    cid_read_c: cover property (access_edge && !pwrite && paddr == OFS_CID0 && powered);
    unmapped_c: cover property (pslverr);
endmodule
`default_nettype wire

//--- cir_pkg.sv
// constants for the card identity register bank
package cir_pkg;
    // clock and power-up timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned POWERUP_US = 10;
    localparam int unsigned POWERUP_CYCLES = POWERUP_US * CLK_MHZ;
    localparam int unsigned WAIT_W = 16;

    // apb byte offsets
    localparam logic [7:0] OFS_OPCOND = 8'h00;
    localparam logic [7:0] OFS_CID0 = 8'h10;
    localparam logic [7:0] OFS_CSD0 = 8'h20;
    localparam logic [7:0] OFS_CTRL = 8'h30;
    localparam logic [7:0] OFS_STAT = 8'h34;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int unsigned CTRL_SECTOR_BIT = 0;
    localparam int unsigned STAT_POWERED_BIT = 0;
    localparam int unsigned STAT_PHASE_LO = 1;

    // operating-conditions word fields
    localparam int unsigned OPC_BUSY_BIT = 31;
    localparam int unsigned OPC_MODE_LO = 29;
    localparam logic [1:0] MODE_BYTE = 2'h0;
    localparam logic [1:0] MODE_SECTOR = 2'h2;
    localparam logic [4:0] OPC_RSVD_HI = 5'h00;
    localparam logic [8:0] OPC_HIGH_V = 9'h1ff;
    localparam logic [6:0] OPC_MID_V = 7'h00;
    localparam logic OPC_LOW_V = 1'b1;
    localparam logic [6:0] OPC_RSVD_LO = 7'h00;

    // identification word constants
    localparam logic [5:0] CID_RSVD = 6'h00;
    localparam logic [1:0] CID_PKG_TYPE = 2'h1;
    localparam logic [7:0] CID_OEM = 8'h00;
    localparam int unsigned CRC_SPAN = 120;
    localparam logic [6:0] CRC_POLY = 7'h09;

    // card-specific-data constants
    localparam logic [1:0] CSD_STRUCT = 2'h3;
    localparam logic [3:0] CSD_SPEC = 4'h4;
    localparam logic [7:0] CSD_ASYNC_ACCESS_TIME = 8'h4f;
    localparam logic [7:0] CSD_CLOCKED_ACCESS_TIME = 8'h01;
    localparam logic [7:0] CSD_MAXCLK = 8'h32;
    localparam logic [11:0] CSD_CLASSES = 12'h0f5;
    localparam logic [3:0] CSD_BLKLEN = 4'h9;
    localparam logic [11:0] CSD_SIZE = 12'hfff;
    localparam logic [2:0] CSD_CURRENT = 3'h7;
    localparam logic [2:0] CSD_SIZE_MULT = 3'h7;
    localparam logic [4:0] CSD_ERASE_SIZE = 5'h1f;
    localparam logic [4:0] CSD_ERASE_MULT = 5'h1f;
    localparam logic [4:0] CSD_PROT_SIZE = 5'h0f;
    localparam logic [2:0] CSD_W_SPEED = 3'h2;
    localparam logic [6:0] CSD_CRC = 7'h30;

    // word store layout
    localparam int unsigned STORE_WORDS = 8;
    localparam int unsigned STORE_AW = 3;

    typedef enum logic [1:0] {
        cir_crc = 2'b00,
        cir_fill = 2'b01,
        cir_wait = 2'b10,
        cir_ready = 2'b11
    } cir_phase_t;
endpackage

//--- cir_word_store.sv
// small word store with registered read data
`timescale 1ns/1ps
`default_nettype none
module cir_word_store #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW = 3
) (
    // clock
    input wire logic clk,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule
`default_nettype wire

//--- cir_host_model.sv
// host-side apb master model for the identity register bank
`timescale 1ns/1ps
`default_nettype none
module cir_host_model (
    // clock
    input wire logic pclk,
    // apb request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // apb answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // host may try writes; the task still hands back the read data and the error flag
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        rd = prdata;
        err = pslverr;
        // released address and write data show the inverse so stale values never look valid
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~wd;
        pstrb <= 4'h0;
    endtask
endmodule
`default_nettype wire

//--- tb_cir_card_regs.sv
// self-checking bench for the identity register bank
`timescale 1ns/1ps
`default_nettype none
module tb_cir_card_regs;
    import cir_pkg::*;
    // arbitrary identity values for the run
    localparam logic [7:0] MAKER = 8'h3c;
    localparam logic [47:0] NAME = 48'h414243444546;
    localparam logic [7:0] REV = 8'h21;
    localparam logic [31:0] SERIAL = 32'h1234_abcd;
    localparam logic [7:0] DATE = 8'h93;
    localparam logic [127:0] CSD_EXP = 128'hd04f0132_0f5903ff_ffffffef_8a400061;
    logic pclk;
    logic presetn;
    wire logic psel;
    wire logic penable;
    wire logic pwrite;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata;
    wire logic [3:0] pstrb;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    int error_cnt = 0;
    int checked = 0;
    logic [127:0] cid_exp;
    logic [31:0] rd;
    logic err;
    logic ok;
    int i;

    cir_card_regs #(.POWERUP_CYCLES_P(4), .MAKER_CODE(MAKER), .PRODUCT_NAME(NAME),
        .PRODUCT_REVISION(REV), .SERIAL_NUMBER(SERIAL), .MANUFACTURE_DATE(DATE)) cir_card_regs_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    cir_host_model cir_host_model_i (
        .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [6:0] crc7(input logic [119:0] d);
        logic [6:0] c;
        logic fb;
        c = 7'h00;
        for (int k = 119; k >= 0; k--) begin
            fb = d[k] ^ c[6];
            c = {c[5:0], 1'b0};
            if (fb) c = c ^ 7'h09;
        end
        return c;
    endfunction

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer; read data masked then compared, error flag always compared
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       input logic [31:0] mask, input logic [31:0] exp, input logic eerr);
        cir_host_model_i.xfer(wr, a, wd, rd, err, ok);
        if (!ok) begin
            error_cnt++;
            $display("mismatch at %0t: no answer from slave", $time);
            close_out();
        end else begin
            if (!wr) chk(rd & mask, exp);
            chk({31'h0, err}, {31'h0, eerr});
        end
    endtask

    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask

    task automatic wait_ready();
        for (i = 0; i < 400; i++) begin
            cir_host_model_i.xfer(1'b0, OFS_OPCOND, 32'h0, rd, err, ok);
            if (rd[31] === 1'b1) break;
        end
        if (i == 400) begin
            error_cnt++;
            $display("mismatch at %0t: power-up never finished", $time);
            close_out();
        end
    endtask

    initial begin
        presetn = 1'b0;
        cid_exp = {MAKER, 6'h00, 2'h1, 8'h00, NAME, REV, SERIAL, DATE, 7'h00, 1'b1};
        cid_exp[7:1] = crc7(cid_exp[127:8]);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, OFS_OPCOND, 32'h0, 32'h8000_0000, 32'h0, 1'b0);
        wait_ready();
        acc(1'b0, OFS_OPCOND, 32'h0, 32'hffff_ffff, 32'h80ff_8080, 1'b0);
        acc(1'b0, OFS_STAT, 32'h0, 32'hffff_ffff, 32'h0000_0007, 1'b0);
        for (int w = 0; w < 4; w++) begin
            acc(1'b0, OFS_CID0 + 8'(4 * w), 32'h0, 32'hffff_ffff, cid_exp[32*w +: 32], 1'b0);
            acc(1'b0, OFS_CSD0 + 8'(4 * w), 32'h0, 32'hffff_ffff, CSD_EXP[32*w +: 32], 1'b0);
        end
        // sector mode through the control register, then back to byte mode
        acc(1'b1, OFS_CTRL, 32'h0000_0001, 32'h0, 32'h0, 1'b0);
        acc(1'b0, OFS_CTRL, 32'h0, 32'hffff_ffff, 32'h0000_0001, 1'b0);
        acc(1'b0, OFS_OPCOND, 32'h0, 32'hffff_ffff, 32'hc0ff_8080, 1'b0);
        acc(1'b1, OFS_CTRL, 32'h0, 32'h0, 32'h0, 1'b0);
        // writes to identity words and status are ignored
        acc(1'b1, OFS_OPCOND, 32'h0, 32'h0, 32'h0, 1'b0);
        acc(1'b1, OFS_CID0 + 8'h0c, 32'h0, 32'h0, 32'h0, 1'b0);
        acc(1'b1, OFS_CSD0, 32'hffff_ffff, 32'h0, 32'h0, 1'b0);
        acc(1'b1, OFS_STAT, 32'hffff_ffff, 32'h0, 32'h0, 1'b0);
        acc(1'b0, OFS_OPCOND, 32'h0, 32'hffff_ffff, 32'h80ff_8080, 1'b0);
        acc(1'b0, OFS_CID0 + 8'h0c, 32'h0, 32'hffff_ffff, cid_exp[127:96], 1'b0);
        acc(1'b0, OFS_CSD0, 32'h0, 32'hffff_ffff, CSD_EXP[31:0], 1'b0);
        // unmapped and misaligned places answer with an error and zero data
        acc(1'b0, 8'h40, 32'h0, 32'hffff_ffff, 32'h0, 1'b1);
        acc(1'b0, 8'h12, 32'h0, 32'hffff_ffff, 32'h0, 1'b1);
        acc(1'b1, 8'h44, 32'h1, 32'h0, 32'h0, 1'b1);
        // second reset in mid-run: busy again, control back to byte mode
        acc(1'b1, OFS_CTRL, 32'h0000_0001, 32'h0, 32'h0, 1'b0);
        do_reset();
        acc(1'b0, OFS_STAT, 32'h0, 32'hffff_ffff, 32'h0000_0000, 1'b0);
        acc(1'b0, OFS_OPCOND, 32'h0, 32'h8000_0000, 32'h0, 1'b0);
        wait_ready();
        acc(1'b0, OFS_OPCOND, 32'h0, 32'hffff_ffff, 32'h80ff_8080, 1'b0);
        acc(1'b0, OFS_CSD0 + 8'h0c, 32'h0, 32'hffff_ffff, CSD_EXP[127:96], 1'b0);
        close_out();
    end
endmodule
`default_nettype wire
